// ==== design/sfp_tx_control_status.sv ====
// Transceiver low-speed control, status pins and management byte slave
`timescale 1ns/1ps
`default_nettype none
`include "sfp_ctl_defs.svh"

// Function
// - Shutdown pin high turns transmitter off
// - Undriven shutdown pin counts as asserted
// - Software shutdown bit ORed with pin
// - Pin state readable in control byte
// - Laser fault raises fault output, stops laser
// - Fault output low normally, high on fault
// - Fault latched until shutdown toggle or reset
// - Fault mirrored into control byte
// - Unsafe optical power stops laser, flags fault
// - Signal-loss output high when input unusable
// - Signal loss mirrored into control byte
// - Control byte lives at serial address A2
module sfp_tx_control_status
  import sfp_ctl_pkg::*;
(
  input  wire logic mclk_in,
  input  wire logic rst_in,
  input  wire logic tx_shutdown_in,
  input  wire logic laser_fault_in,
  input  wire logic power_unsafe_in,
  input  wire logic rx_level_bad_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_out,
  output logic      laser_enable_out,
  output logic      tx_fault_out,
  output logic      receive_signal_absent_out
);

  // ----------------------------------------------------------------
  // Byte decode helpers
  // ----------------------------------------------------------------
  // True when the pointer selects the control and status byte
  function automatic logic hits_ctrl(input logic [7:0] ptr);
    return ptr == `CTRL_OFFSET;
  endfunction

  // Read data for a pointer; the rest of the space reads as zero
  function automatic logic [7:0] read_byte(input logic [7:0] ptr,
                                           input logic [7:0] ctrl);
    return hits_ctrl(ptr) ? ctrl : `BYTE_ZERO;
  endfunction

  serial_s    s;
  serial_s    n;
  logic       pin_state;
  logic       fault_latched;
  logic [7:0] ctrl_byte;
  logic [7:0] rd_byte;
  logic       scl_rise;
  logic       scl_fall;
  logic       start;
  logic       stop;

  // ----------------------------------------------------------------
  // Transmit guard
  // ----------------------------------------------------------------
  laser_guard u_guard (
    .mclk_in           (mclk_in),
    .rst_in            (rst_in),
    .shutdown_pin_in   (tx_shutdown_in),
    .soft_off_in       (s.soft_off),
    .fault_detect_in   (laser_fault_in),
    .unsafe_power_in   (power_unsafe_in),
    .pin_state_out     (pin_state),
    .fault_latched_out (fault_latched),
    .laser_enable_out  (laser_enable_out)
  );

  // ----------------------------------------------------------------
  // Control and status byte image
  // ----------------------------------------------------------------
  // Live status bits plus the stored software shutdown bit
  always_comb begin
    ctrl_byte                  = `BYTE_ZERO;
    ctrl_byte[`BIT_PIN_STATE]  = pin_state;
    ctrl_byte[`BIT_SOFT_OFF]   = s.soft_off;
    ctrl_byte[`BIT_FAULT]      = fault_latched;
    ctrl_byte[`BIT_SIG_ABSENT] = s.sig_absent & `DIAG_MONITORING;
    rd_byte                    = read_byte(s.ptr, ctrl_byte);
  end

  // Bus line events seen against the previous samples
  assign scl_rise = scl_in & ~s.scl_q;
  assign scl_fall = ~scl_in & s.scl_q;
  assign start    = scl_in & s.scl_q & s.sda_q & ~sda_in;
  assign stop     = scl_in & s.scl_q & ~s.sda_q & sda_in;

  // ----------------------------------------------------------------
  // Serial slave next state
  // ----------------------------------------------------------------
  // Byte engine: address, offset, write data, read data and acks
  always_comb begin
    n            = s;
    n.scl_q      = scl_in;
    n.sda_q      = sda_in;
    n.sig_absent = rx_level_bad_in;
    if (start) begin
      n.st     = ST_ADDR;
      n.bitcnt = `BITCNT_ZERO;
      n.oe     = 1'h0;
    end else if (stop) begin
      n.st = ST_IDLE;
      n.oe = 1'h0;
    end else begin
      case (s.st)
        ST_ADDR, ST_OFFS, ST_WDATA: begin
          if (scl_rise) begin
            n.shreg  = {s.shreg[6:0], sda_in};
            n.bitcnt = s.bitcnt + `BITCNT_STEP;
          end else if (scl_fall && s.bitcnt == `BITCNT_FULL) begin
            n.bitcnt = `BITCNT_ZERO;
            n.oe     = 1'h1;
            n.st     = ST_ACK;
            n.after  = ST_WDATA;
            if (s.st == ST_ADDR) begin
              // Only the diagnostic space address is answered
              if (s.shreg[7:1] == `DEV_ADDR7) begin
                n.after = s.shreg[0] ? ST_RDATA : ST_OFFS;
              end else begin
                n.oe = 1'h0;
                n.st = ST_IDLE;
              end
            end else if (s.st == ST_OFFS) begin
              n.ptr = s.shreg;
            end else begin
              // Only the software shutdown bit takes a write
              if (hits_ctrl(s.ptr)) begin
                n.soft_off = s.shreg[`BIT_SOFT_OFF];
              end
              n.ptr = s.ptr + `PTR_STEP;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            n.oe = 1'h0;
            n.st = s.after;
            if (s.after == ST_RDATA) begin
              n.shreg  = rd_byte;
              n.oe     = ~rd_byte[7];
              n.ptr    = s.ptr + `PTR_STEP;
              n.bitcnt = `BITCNT_ZERO;
            end
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (s.bitcnt == `BITCNT_LAST) begin
              n.oe     = 1'h0;
              n.st     = ST_MACK;
              n.bitcnt = `BITCNT_ZERO;
            end else begin
              n.shreg  = {s.shreg[6:0], 1'h0};
              n.oe     = ~s.shreg[6];
              n.bitcnt = s.bitcnt + `BITCNT_STEP;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            n.nack = sda_in;
          end else if (scl_fall) begin
            if (s.nack) begin
              n.st = ST_IDLE;
            end else begin
              n.shreg  = rd_byte;
              n.oe     = ~rd_byte[7];
              n.ptr    = s.ptr + `PTR_STEP;
              n.st     = ST_RDATA;
            end
          end
        end
        default: begin
          n.oe = 1'h0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Bus lines idle high; software shutdown clear after reset
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s <= '{scl_q: 1'h1, sda_q: 1'h1, st: ST_IDLE, after: ST_IDLE,
             bitcnt: `BITCNT_ZERO, shreg: `BYTE_ZERO, ptr: `BYTE_ZERO,
             nack: 1'h0, oe: 1'h0, soft_off: 1'h0, sig_absent: 1'h0};
    end else begin
      s <= n;
    end
  end

  // Open-drain data line only ever pulls low
  assign sda_out                   = 1'h0;
  assign sda_oe_out                = s.oe;
  assign tx_fault_out              = fault_latched;
  assign receive_signal_absent_out = s.sig_absent;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  fault_pin_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    laser_fault_in |=> (tx_fault_out && !laser_enable_out))
    else $error("fault pin not raised after laser fault");

  power_trip_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    power_unsafe_in |=> (tx_fault_out && !laser_enable_out) [*2])
    else $error("unsafe power did not trip transmitter");

  loss_follow_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    1'h1 |=> (receive_signal_absent_out == $past(rx_level_bad_in)))
    else $error("signal loss output does not follow detector");

  loss_mirror_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    receive_signal_absent_out |-> ctrl_byte[`BIT_SIG_ABSENT])
    else $error("signal loss not mirrored in status byte");

  fault_mirror_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    laser_fault_in |=> ctrl_byte[`BIT_FAULT])
    else $error("fault not mirrored in status byte");

  addr_reject_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (s.st == ST_ADDR && scl_fall && !start && !stop && s.bitcnt == `BITCNT_FULL
     && s.shreg[7:1] != `DEV_ADDR7) |=> (!sda_oe_out && s.st == ST_IDLE))
    else $error("foreign device address was acknowledged");

  pin_readout_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (s.st == ST_ACK && s.after == ST_RDATA && scl_fall && !start && !stop
     && hits_ctrl(s.ptr)) |=> (sda_oe_out == !$past(pin_state)))
    else $error("first read bit does not show shutdown pin");

  soft_write_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (s.st == ST_WDATA && scl_fall && !start && !stop && s.bitcnt == `BITCNT_FULL
     && hits_ctrl(s.ptr) && s.shreg[`BIT_SOFT_OFF]) |=> ##1 !laser_enable_out)
    else $error("software shutdown write did not stop laser");

endmodule

`default_nettype wire

// ==== design/sfp_ctl_defs.svh ====
// Constants for the transceiver transmit control and status block
`ifndef SFP_CTL_DEFS_SVH
`define SFP_CTL_DEFS_SVH

// ----------------------------------------------------------------
// Management space on the 2-wire bus
// ----------------------------------------------------------------
`define DEV_ADDR7        7'h51
`define CTRL_OFFSET      8'h6E
`define PTR_STEP         8'h01
`define BYTE_ZERO        8'h00

// ----------------------------------------------------------------
// Field positions inside the control and status byte
// ----------------------------------------------------------------
`define BIT_PIN_STATE    7
`define BIT_SOFT_OFF     6
`define BIT_FAULT        2
`define BIT_SIG_ABSENT   1

// ----------------------------------------------------------------
// Options and bit counters
// ----------------------------------------------------------------
`define DIAG_MONITORING  1'h1
`define BITCNT_ZERO      4'h0
`define BITCNT_STEP      4'h1
`define BITCNT_LAST      4'h7
`define BITCNT_FULL      4'h8

`endif

// ==== design/sfp_ctl_pkg.sv ====
// Types shared by the transceiver transmit control and status block
`default_nettype none

package sfp_ctl_pkg;

  // ----------------------------------------------------------------
  // Serial slave states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_ADDR  = 7'h02,
    ST_OFFS  = 7'h04,
    ST_WDATA = 7'h08,
    ST_ACK   = 7'h10,
    ST_RDATA = 7'h20,
    ST_MACK  = 7'h40
  } wire_state_e;

  // ----------------------------------------------------------------
  // Module state records
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        scl_q;
    logic        sda_q;
    wire_state_e st;
    wire_state_e after;
    logic [3:0]  bitcnt;
    logic [7:0]  shreg;
    logic [7:0]  ptr;
    logic        nack;
    logic        oe;
    logic        soft_off;
    logic        sig_absent;
  } serial_s;

  typedef struct packed {
    logic pin;
    logic eff;
    logic fault;
    logic en;
  } guard_s;

endpackage

`default_nettype wire

// ==== design/laser_guard.sv ====
// Transmit shutdown combining, fault latch and laser enable
`timescale 1ns/1ps
`default_nettype none
`include "sfp_ctl_defs.svh"

module laser_guard
  import sfp_ctl_pkg::*;
(
  input  wire logic mclk_in,
  input  wire logic rst_in,
  input  wire logic shutdown_pin_in,
  input  wire logic soft_off_in,
  input  wire logic fault_detect_in,
  input  wire logic unsafe_power_in,
  output logic      pin_state_out,
  output logic      fault_latched_out,
  output logic      laser_enable_out
);

  guard_s s;
  guard_s n;
  logic   eff;
  logic   hit;
  logic   clear_seq;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Shutdown sources ORed; fault sources set the latch
  always_comb begin
    eff       = s.pin | soft_off_in;
    hit       = fault_detect_in | unsafe_power_in;
    clear_seq = s.eff & ~eff;
    n         = s;
    n.pin     = shutdown_pin_in;
    n.eff     = eff;
    // Set wins over the toggle clear, so a lasting fault re-latches
    n.fault   = hit | (s.fault & ~clear_seq);
    n.en      = ~(eff | n.fault);
  end

  // Pin sample resets high so an undriven input keeps the laser off
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s <= '{pin: 1'h1, eff: 1'h1, fault: 1'h0, en: 1'h0};
    end else begin
      s <= n;
    end
  end

  // Outputs straight from flip-flops
  assign pin_state_out     = s.pin;
  assign fault_latched_out = s.fault;
  assign laser_enable_out  = s.en;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  pin_off_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    shutdown_pin_in |-> ##2 !laser_enable_out)
    else $error("laser on two cycles after shutdown pin high");

  pin_default_a: assert property (
    @(posedge mclk_in)
    rst_in |=> (!laser_enable_out && pin_state_out))
    else $error("laser not held off after reset");

  soft_off_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    soft_off_in |=> !laser_enable_out)
    else $error("laser on while software shutdown set");

  fault_set_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    hit |=> (fault_latched_out && !laser_enable_out))
    else $error("fault did not latch and stop laser");

  fault_hold_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (fault_latched_out && !clear_seq) |=> fault_latched_out)
    else $error("fault latch dropped without a toggle");

  toggle_clear_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (fault_latched_out && clear_seq && !hit) |=> !fault_latched_out)
    else $error("fault latch not cleared by shutdown toggle");

  laser_on_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (!eff && !n.fault) |=> laser_enable_out)
    else $error("laser stayed off with no cause");

endmodule

`default_nettype wire

// ==== tb/host_ctl_model.sv ====
// Host board controller model: shutdown pin and 2-wire master
`timescale 1ns/1ps
`default_nettype none

module host_ctl_model #(
  parameter int HB  = 4,
  parameter int GAP = 2000
) (
  input  wire logic mclk_in,
  input  wire logic sda_in,
  output logic      pin_out,
  output logic      scl_out,
  output logic      pull_out
);
  logic drv;
  logic val;
  int   cyc;
  int   last;

  // ----------------------------------------------------------------
  // Shutdown pin
  // ----------------------------------------------------------------
  // Undriven pin reads high through the pull-up; driven to the set_pin value once set
  assign pin_out = drv ? val : 1'b1;

  // Idle bus, pin left floating
  initial begin
    drv = 1'b0;
    val = 1'b0;
    cyc = 0;
    last = -GAP;
    scl_out = 1'b1;
    pull_out = 1'b0;
  end

  // Cycle count for assertion spacing
  always @(posedge mclk_in) cyc <= cyc + 1;

  // Spacing shortened from 10 ms so the run stays short
  task automatic set_pin(input logic v);
    @(posedge mclk_in);
    while (v && cyc - last < GAP) @(posedge mclk_in);
    if (v) last = cyc;
    drv <= 1'b1;
    val <= v;
  endtask

  // ----------------------------------------------------------------
  // 2-wire master, SDA moves while SCL is high only for START and STOP
  // ----------------------------------------------------------------
  task automatic hb();
    repeat (HB) @(posedge mclk_in);
  endtask

  task automatic put(input logic b);
    pull_out <= ~b;
    hb();
    scl_out <= 1'b1;
    hb();
    scl_out <= 1'b0;
    hb();
  endtask

  task automatic get(output logic b);
    pull_out <= 1'b0;
    hb();
    scl_out <= 1'b1;
    hb();
    b = sda_in;
    scl_out <= 1'b0;
    hb();
  endtask

  task automatic start();
    pull_out <= 1'b0;
    hb();
    scl_out <= 1'b1;
    hb();
    pull_out <= 1'b1;
    hb();
    scl_out <= 1'b0;
    hb();
  endtask

  task automatic stop();
    pull_out <= 1'b1;
    hb();
    scl_out <= 1'b1;
    hb();
    pull_out <= 1'b0;
    hb();
  endtask

  // Byte out MSB first, then the slave's acknowledge
  task automatic wbyte(input logic [7:0] d, inout logic ok);
    logic a;
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(a);
    ok = ok & (a === 1'b0);
  endtask

  // Byte in, master ends with a not-acknowledge
  task automatic rbyte(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get(d[i]);
    put(1'b1);
  endtask

  task automatic wr(input logic [6:0] dev, input logic [7:0] off,
                    input logic [7:0] d, output logic ok);
    ok = 1'b1;
    @(posedge mclk_in);
    start();
    wbyte({dev, 1'b0}, ok);
    wbyte(off, ok);
    wbyte(d, ok);
    stop();
  endtask

  // Offset set by a write, then repeated START and one read
  task automatic rd(input logic [6:0] dev, input logic [7:0] off,
                    output logic [7:0] d, output logic ok);
    ok = 1'b1;
    @(posedge mclk_in);
    start();
    wbyte({dev, 1'b0}, ok);
    wbyte(off, ok);
    start();
    wbyte({dev, 1'b1}, ok);
    rbyte(d);
    stop();
  endtask
endmodule

`default_nettype wire

// ==== tb/tb_sfp_tx_control_status.sv ====
// Self-checking bench for the transmit control and status block
`timescale 1ns/1ps
`default_nettype none
`include "sfp_ctl_defs.svh"

module tb_sfp_tx_control_status;
  logic       mclk_in;
  logic       rst_in;
  logic       laser_fault_in;
  logic       power_unsafe_in;
  logic       rx_level_bad_in;
  logic       pin;
  logic       scl;
  logic       pull;
  logic       sda_wire;
  logic       sda_out;
  logic       sda_oe_out;
  logic       laser_en;
  logic       fault;
  logic       absent;
  logic [7:0] rdata;
  logic       ok;
  int         err_total = 0;
  int         samples_checked = 0;

  // Open-drain SDA with pull-up
  assign sda_wire = ~(pull | (sda_oe_out & ~sda_out));

  // Clock
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end

  sfp_tx_control_status i_sfp_tx_control_status (
    .mclk_in                   (mclk_in),
    .rst_in                    (rst_in),
    .tx_shutdown_in            (pin),
    .laser_fault_in            (laser_fault_in),
    .power_unsafe_in           (power_unsafe_in),
    .rx_level_bad_in           (rx_level_bad_in),
    .scl_in                    (scl),
    .sda_in                    (sda_wire),
    .sda_out                   (sda_out),
    .sda_oe_out                (sda_oe_out),
    .laser_enable_out          (laser_en),
    .tx_fault_out              (fault),
    .receive_signal_absent_out (absent)
  );

  host_ctl_model i_host_ctl_model (
    .mclk_in  (mclk_in),
    .sda_in   (sda_wire),
    .pin_out  (pin),
    .scl_out  (scl),
    .pull_out (pull)
  );

  // ----------------------------------------------------------------
  // Compare and helper tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  // Expected control byte from pin, soft bit, fault and signal loss
  function automatic logic [7:0] ctl(input logic p, input logic s,
                                     input logic f, input logic a);
    ctl = 8'h00;
    ctl[`BIT_PIN_STATE] = p;
    ctl[`BIT_SOFT_OFF] = s;
    ctl[`BIT_FAULT] = f;
    ctl[`BIT_SIG_ABSENT] = a & `DIAG_MONITORING;
  endfunction

  task automatic rd_chk(input logic [7:0] exp);
    i_host_ctl_model.rd(`DEV_ADDR7, `CTRL_OFFSET, rdata, ok);
    chk(ok, 1'b1, "read ack");
    chk8(rdata, exp, "control byte");
  endtask

  task automatic toggle();
    i_host_ctl_model.set_pin(1'b1);
    step(3);
    i_host_ctl_model.set_pin(1'b0);
    step(2);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset values, floating pin, then pin grounded
  task automatic t_reset();
    step(3);
    chk(laser_en, 1'b0, "laser in reset");
    chk(fault, 1'b0, "fault in reset");
    chk(sda_oe_out, 1'b0, "sda in reset");
    chk(absent, 1'b0, "absent in reset");
    repeat (3) @(posedge mclk_in);
    rst_in <= 1'b0;
    step(8);
    chk(laser_en, 1'b0, "floating pin");
    rd_chk(ctl(1'b1, 1'b0, 1'b0, 1'b0));
    i_host_ctl_model.set_pin(1'b0);
    step(2);
    chk(laser_en, 1'b1, "grounded pin");
  endtask

  // Pin shutdown with exact latency and mirrored pin state
  task automatic t_pin();
    i_host_ctl_model.set_pin(1'b1);
    step(1);
    chk(laser_en, 1'b1, "shutdown early");
    step(1);
    chk(laser_en, 1'b0, "shutdown");
    rd_chk(ctl(1'b1, 1'b0, 1'b0, 1'b0));
    i_host_ctl_model.set_pin(1'b0);
    step(2);
    chk(laser_en, 1'b1, "release");
  endtask

  // Laser fault pulse latches until pin toggle
  task automatic t_fault();
    @(posedge mclk_in);
    laser_fault_in <= 1'b1;
    step(1);
    chk(fault, 1'b1, "fault raised");
    chk(laser_en, 1'b0, "fault laser");
    @(posedge mclk_in);
    laser_fault_in <= 1'b0;
    step(10);
    chk(fault, 1'b1, "fault held");
    rd_chk(ctl(1'b0, 1'b0, 1'b1, 1'b0));
    toggle();
    chk(fault, 1'b0, "fault cleared");
    chk(laser_en, 1'b1, "laser back");
  endtask

  // Lasting unsafe power re-latches across a toggle
  task automatic t_unsafe();
    @(posedge mclk_in);
    power_unsafe_in <= 1'b1;
    step(1);
    chk(fault, 1'b1, "unsafe fault");
    chk(laser_en, 1'b0, "unsafe laser");
    toggle();
    chk(fault, 1'b1, "relatch");
    chk(laser_en, 1'b0, "relatch laser");
    @(posedge mclk_in);
    power_unsafe_in <= 1'b0;
    toggle();
    chk(fault, 1'b0, "unsafe cleared");
    chk(laser_en, 1'b1, "unsafe laser back");
  endtask

  // Soft shutdown, read-only bits, clear through the soft bit
  task automatic t_soft();
    @(posedge mclk_in);
    laser_fault_in <= 1'b1;
    @(posedge mclk_in);
    laser_fault_in <= 1'b0;
    i_host_ctl_model.wr(`DEV_ADDR7, `CTRL_OFFSET, 8'hFF, ok);
    chk(ok, 1'b1, "write ack");
    chk(laser_en, 1'b0, "soft off");
    rd_chk(ctl(1'b0, 1'b1, 1'b1, 1'b0));
    i_host_ctl_model.wr(`DEV_ADDR7, `CTRL_OFFSET, 8'h00, ok);
    chk(fault, 1'b0, "soft clear");
    chk(laser_en, 1'b1, "soft on");
  endtask

  // Signal loss pin and mirror
  task automatic t_absent();
    @(posedge mclk_in);
    rx_level_bad_in <= 1'b1;
    step(1);
    chk(absent, 1'b1, "absent high");
    rd_chk(ctl(1'b0, 1'b0, 1'b0, 1'b1));
    @(posedge mclk_in);
    rx_level_bad_in <= 1'b0;
    step(1);
    chk(absent, 1'b0, "absent low");
  endtask

  // Foreign address ignored, unmapped offset reads zero
  task automatic t_refuse();
    i_host_ctl_model.wr(7'h50, `CTRL_OFFSET, 8'h40, ok);
    chk(ok, 1'b0, "foreign ack");
    chk(laser_en, 1'b1, "foreign write");
    i_host_ctl_model.rd(`DEV_ADDR7, 8'h6F, rdata, ok);
    chk(ok, 1'b1, "other ack");
    chk8(rdata, 8'h00, "other byte");
  endtask

  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst_in = 1'b1;
    laser_fault_in = 1'b0;
    power_unsafe_in = 1'b0;
    rx_level_bad_in = 1'b0;
    t_reset();
    t_pin();
    t_fault();
    t_unsafe();
    t_soft();
    t_absent();
    t_refuse();
    give_verdict();
  end

  // Run limit against a hang
  initial begin
    repeat (80000) @(posedge mclk_in);
    err_total++;
    $display("mismatch at %0t: run limit reached", $time);
    give_verdict();
  end
endmodule

`default_nettype wire
